// file: core/timer_pkg.sv
// constants, register layout and carrier types for the standard timer block
// assumes a 32-bit classic wishbone slave at 125 MHz, one clock domain
// Summary of operation
// (RQ1) mode field 00 selects compare match output mode
// (RQ2) clear select low: clear on P match or overflow; both flags raised
// (RQ3) clear select high: clear on A match; only A flag, never P flag
// (RQ4) software keeps compare A nonzero in compare match output mode
// (RQ5) compare A zero: counter wraps at 3ff, no A flag for it
// (RQ6) in compare match mode only an A match moves the pin
// (RQ7) A match drives pin high, low or toggles per pin function; zero keeps
// (RQ8) pin function: 00 keep, 01 low, 10 high, 11 toggle
// (RQ9) run rising loads the pin with the initial level
// (RQ10) run rising zeroes counter; run falling freezes the count
// (RQ11) mode 11 behaves as compare mode with flags but pin undriven
// (RQ12) mode 10 with pin function 10 gives pwm output
// (RQ13) swap 0: period is P times 128 or 1024, duty is A
// (RQ14) swap 1: period is A, duty is P times 128; the code uses a duty of 1024 when P is zero
// (RQ15) duty at or above period holds output fully active
// (RQ16) in pwm each A match sets A flag, each P match sets P flag
// (RQ17) pwm pin function 00/01 forces inactive/active, counting continues
// (RQ18) pwm level control picks active polarity; invert flips final output
// (RQ19) pwm ignores clear select; period comparator clear sets the period
// (RQ20) mode 10 with pin function 11 gives a single pulse
// (RQ21) run rise by software or external pin edge starts pulse and counter
// (RQ22) pulse: A match clears run, ends pulse, sets A flag; software clear too
// (RQ23) pulse: counter resets only on run rise; P, clear select, swap unused
// (RQ24) software keeps run high while the pulse should stay active
// (RQ25) output invert set inverts pin level, clear passes it
// (RQ26) while running counter steps once per timer tick; matches set flags
package timer_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int COUNT_W = 10;
    localparam int CMP_P_W = 3;
    localparam int P_SHIFT = 7;
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMPA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DIVIDER = 8'h14;
    localparam int RUN_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [9:0] CMPA_RESET = 10'h000;
    localparam logic [2:0] CMPP_RESET = 3'h0;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAPT = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] PF_KEEP = 2'h0;
    localparam logic [1:0] PF_LOW = 2'h1;
    localparam logic [1:0] PF_HIGH = 2'h2;
    localparam logic [1:0] PF_TOGGLE = 2'h3;
    localparam logic [1:0] PF_PWM_OFF = 2'h0;
    localparam logic [1:0] PF_PWM_ON = 2'h1;
    localparam logic [1:0] PF_PWM = 2'h2;
    localparam logic [1:0] PF_PULSE = 2'h3;

    // timer_control_one layout, msb first
    typedef struct packed {
        logic [1:0] mode_select;
        logic [1:0] pin_function_select;
        logic output_level_control;
        logic output_invert;
        logic duty_period_swap;
        logic counter_clear_select;
    } timer_control_one_t;

    typedef enum logic [4:0] {
        OP_CMP = 5'b00001,
        OP_CAPT = 5'b00010,
        OP_PWM = 5'b00100,
        OP_PULSE = 5'b01000,
        OP_TIMER = 5'b10000
    } op_t;

    typedef struct packed {
        logic a;
        logic p;
        logic ovf;
    } match_t;
endpackage

// file: core/standard_timer.sv
// standard timer: 10-bit up counter, comparators a and p, output modes
// assumes a classic wishbone master on clk; external_clock_pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
module standard_timer
    import timer_pkg::*;
#(
    parameter int DIV_W = 8 // width of the timer tick divider
) (
    input wire logic clk, // system clock, 125 MHz
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte enables
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic external_clock_pin, // pulse trigger pin, rising edge
    output logic timer_out, // timer output pin level
    output logic timer_out_en // high while the timer drives the pin
);

    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("standard_timer: DIV_W must lie between 1 and 16");
        end
    end

    timer_control_one_t ctrl;
    logic [COUNT_W-1:0] compare_a_value;
    logic [CMP_P_W-1:0] compare_p_value;
    logic [COUNT_W-1:0] count;
    logic [DIV_W-1:0] divider;
    logic [DIV_W-1:0] div_count;
    logic counter_run;
    logic run_prev;
    logic match_a_flag;
    logic match_p_flag;
    logic pin_state;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic tick;
    logic run_rise;
    logic step;
    op_t op;
    match_t hit;
    logic [COUNT_W:0] count_next;
    logic [COUNT_W:0] period_len;
    logic [COUNT_W:0] duty_len;
    logic clear_now;
    logic set_a;
    logic set_p;
    logic pwm_active;
    logic next_timer_out;
    logic next_timer_out_en;
    logic bus_req;
    logic bus_wr;
    logic ext_rise;
    logic [31:0] read_mux;

    // p compare value scaled to counter units; zero means the full range
    function automatic logic [COUNT_W:0] p_span(input logic [CMP_P_W-1:0] p);
        logic [COUNT_W:0] span;
        span = {1'b0, p, {P_SHIFT{1'b0}}};
        if (p == '0) begin
            span = {1'b1, {COUNT_W{1'b0}}};
        end
        return span;
    endfunction

    function automatic op_t decode_op(input timer_control_one_t c);
        op_t o;
        o = OP_CMP;
        case (c.mode_select)
            MODE_CMP: o = OP_CMP; // [RQ1]
            MODE_CAPT: o = OP_CAPT;
            MODE_PWM: o = (c.pin_function_select == PF_PULSE) ? OP_PULSE : OP_PWM; // [RQ12] [RQ20]
            MODE_TIMER: o = OP_TIMER; // [RQ11]
            default: o = OP_CMP;
        endcase
        return o;
    endfunction

    function automatic logic lane_write(input logic [7:0] adr, input logic [7:0] target,
                                        input logic wr, input logic [3:0] sel,
                                        input int lane);
        return wr && (adr == target) && sel[lane];
    endfunction

    assign op = decode_op(ctrl);
    assign bus_req = wb_cyc_i && wb_stb_i;
    // writes land on the edge where the master sees ack high
    assign bus_wr = bus_req && wb_we_i && wb_ack_o;

    // external pin: two flip-flops, then an edge detector on the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync1 <= external_clock_pin;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    assign ext_rise = ext_sync2 && !ext_prev;

    // timer tick divider: one-cycle enable every divider+1 clocks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= '0;
        end else if (div_count == '0) begin
            div_count <= divider;
        end else begin
            div_count <= div_count - 1'b1;
        end
    end

    assign tick = (div_count == '0);
    assign run_rise = counter_run && !run_prev;
    // the rise cycle itself only zeroes the counter, so a tick there is skipped
    assign step = counter_run && tick && !run_rise; // [RQ26]
    assign count_next = {1'b0, count} + 11'h001;

    // comparators look at the value the counter is about to take
    always_comb begin
        hit.a = step && (count_next == {1'b0, compare_a_value}); // [RQ5]
        hit.p = step && (compare_p_value != '0)
                && (count_next == {1'b0, compare_p_value, {P_SHIFT{1'b0}}});
        hit.ovf = step && (count == COUNT_MAX);
    end

    // pwm period and duty by swap selection
    always_comb begin
        if (ctrl.duty_period_swap) begin
            period_len = {1'b0, compare_a_value}; // [RQ14]
            duty_len = p_span(compare_p_value);
        end else begin
            period_len = p_span(compare_p_value); // [RQ13]
            duty_len = {1'b0, compare_a_value};
        end
    end

    // clear decision and flag events per mode
    always_comb begin
        clear_now = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        case (op)
            OP_CMP, OP_TIMER: begin
                if (ctrl.counter_clear_select) begin
                    clear_now = hit.a; // [RQ3]
                    set_a = hit.a; // [RQ3]
                end else begin
                    clear_now = hit.p || (hit.ovf && compare_p_value == '0); // [RQ2]
                    set_a = hit.a; // [RQ2]
                    set_p = hit.p || (hit.ovf && compare_p_value == '0); // [RQ2]
                end
            end
            OP_PWM: begin
                // clear select is not consulted here
                clear_now = step && (count_next == period_len); // [RQ19]
                set_a = hit.a; // [RQ16]
                set_p = hit.p || (hit.ovf && compare_p_value == '0); // [RQ16]
            end
            OP_PULSE: begin
                // counter only wraps; p, clear select and swap play no part
                clear_now = 1'b0; // [RQ23]
                set_a = hit.a; // [RQ22]
            end
            OP_CAPT: begin
                clear_now = hit.p;
                set_p = hit.p;
            end
            default: begin
                clear_now = 1'b0;
            end
        endcase
    end

    // counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (run_rise) begin
            count <= '0; // [RQ10] [RQ21]
        end else if (step) begin
            if (clear_now) begin
                count <= '0;
            end else begin
                count <= count_next[COUNT_W-1:0]; // [RQ26]
            end
        end
    end

    // run bit: software write, pin trigger in pulse mode, a match ends pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_run <= 1'b0;
            run_prev <= 1'b0;
        end else begin
            run_prev <= counter_run;
            if (lane_write(wb_adr_i, ADDR_CTRL0, bus_wr, wb_sel_i, 0)) begin
                counter_run <= wb_dat_i[RUN_BIT]; // [RQ22]
            end else if (op == OP_PULSE && hit.a) begin
                counter_run <= 1'b0; // [RQ22]
            end else if (op == OP_PULSE && ext_rise) begin
                counter_run <= 1'b1; // [RQ21]
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= CTRL1_RESET;
            compare_a_value <= CMPA_RESET;
            compare_p_value <= CMPP_RESET;
            divider <= '0;
        end else begin
            if (lane_write(wb_adr_i, ADDR_CTRL0, bus_wr, wb_sel_i, 0)) begin
                compare_p_value <= wb_dat_i[CMP_P_W-1:0];
            end
            if (lane_write(wb_adr_i, ADDR_CTRL1, bus_wr, wb_sel_i, 0)) begin
                ctrl <= wb_dat_i[7:0];
            end
            if (lane_write(wb_adr_i, ADDR_CMPA, bus_wr, wb_sel_i, 0)) begin
                compare_a_value[7:0] <= wb_dat_i[7:0];
            end
            if (lane_write(wb_adr_i, ADDR_CMPA, bus_wr, wb_sel_i, 1)) begin
                compare_a_value[COUNT_W-1:8] <= wb_dat_i[COUNT_W-1:8];
            end
            if (lane_write(wb_adr_i, ADDR_DIVIDER, bus_wr, wb_sel_i, 0)) begin
                divider[DIV_W-1:0] <= wb_dat_i[DIV_W-1:0];
            end
        end
    end

    // match flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            if (set_a) begin
                match_a_flag <= 1'b1; // [RQ26]
            end else if (lane_write(wb_adr_i, ADDR_STATUS, bus_wr, wb_sel_i, 0)
                         && wb_dat_i[FLAG_A_BIT]) begin
                match_a_flag <= 1'b0;
            end
            if (set_p) begin
                match_p_flag <= 1'b1; // [RQ26]
            end else if (lane_write(wb_adr_i, ADDR_STATUS, bus_wr, wb_sel_i, 0)
                         && wb_dat_i[FLAG_P_BIT]) begin
                match_p_flag <= 1'b0;
            end
        end
    end

    // compare mode pin state: loaded on run rise, moved only by an a match
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_state <= 1'b0;
        end else if (run_rise) begin
            pin_state <= ctrl.output_level_control; // [RQ9]
        end else if (op == OP_CMP && set_a) begin // [RQ6]
            case (ctrl.pin_function_select)
                PF_KEEP: pin_state <= pin_state; // [RQ7] [RQ8]
                PF_LOW: pin_state <= 1'b0; // [RQ8]
                PF_HIGH: pin_state <= 1'b1; // [RQ8]
                PF_TOGGLE: pin_state <= !pin_state; // [RQ7] [RQ8]
                default: pin_state <= pin_state;
            endcase
        end
    end

    // pwm waveform; duty at or past the period keeps it active all period
    assign pwm_active = (duty_len >= period_len) || ({1'b0, count} < duty_len); // [RQ15]

    always_comb begin
        next_timer_out = 1'b0;
        next_timer_out_en = 1'b0;
        case (op)
            OP_CMP: begin
                next_timer_out = pin_state ^ ctrl.output_invert; // [RQ25]
                next_timer_out_en = 1'b1;
            end
            OP_PWM: begin
                next_timer_out_en = 1'b1;
                case (ctrl.pin_function_select)
                    PF_PWM_OFF: next_timer_out = !ctrl.output_level_control; // [RQ17]
                    PF_PWM_ON: next_timer_out = ctrl.output_level_control; // [RQ17]
                    default: next_timer_out = pwm_active ? ctrl.output_level_control
                                                         : !ctrl.output_level_control; // [RQ18]
                endcase
                next_timer_out = next_timer_out ^ ctrl.output_invert; // [RQ18] [RQ25]
            end
            OP_PULSE: begin
                // pulse is active exactly while run is high
                next_timer_out = (counter_run ? ctrl.output_level_control
                                              : !ctrl.output_level_control)
                                 ^ ctrl.output_invert; // [RQ21] [RQ22] [RQ25]
                next_timer_out_en = 1'b1;
            end
            OP_TIMER: begin
                next_timer_out = 1'b0; // [RQ11]
                next_timer_out_en = 1'b0; // [RQ11]
            end
            default: begin
                next_timer_out = 1'b0;
                next_timer_out_en = 1'b0;
            end
        endcase
    end

    // pin registered so it never glitches on comparator decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_out <= 1'b0;
            timer_out_en <= 1'b0;
        end else begin
            timer_out <= next_timer_out;
            timer_out_en <= next_timer_out_en;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        read_mux = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_CTRL0: begin
                read_mux[RUN_BIT] = counter_run;
                read_mux[CMP_P_W-1:0] = compare_p_value;
            end
            ADDR_CTRL1: read_mux[7:0] = ctrl;
            ADDR_COUNT: read_mux[COUNT_W-1:0] = count;
            ADDR_CMPA: read_mux[COUNT_W-1:0] = compare_a_value;
            ADDR_STATUS: begin
                read_mux[FLAG_A_BIT] = match_a_flag;
                read_mux[FLAG_P_BIT] = match_p_flag;
            end
            ADDR_DIVIDER: read_mux[DIV_W-1:0] = divider;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // one wait state: ack in the cycle after the request, dropped next cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= read_mux;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/standard_timer_chk.sv
// port checker for the standard timer; shadows control writes seen on the bus
// assumes one clock domain and single bus cycles with an idle cycle between
`timescale 1ns/100ps
`default_nettype none
module standard_timer_chk
    import timer_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [7:0] wb_adr_i, // bus address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic wb_ack_o, // acknowledge
    input wire logic timer_out, // pin level
    input wire logic timer_out_en // pin drive enable
);
    logic [7:0] ctrl;
    logic run;
    logic [2:0] quiet;
    logic wr;
    logic settled;
    logic init_lvl;
    assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    // pin rules other than the run load are only judged once a config write has had time to land
    assign settled = quiet >= 3'h3;
    assign init_lvl = ctrl[3] ^ ctrl[2];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet <= 3'h0;
        end else if (wr) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= 8'h00;
        end else if (wr && wb_adr_i == ADDR_CTRL1 && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[7:0];
        end
    end
    // tracks software writes only; hardware run changes happen in pulse mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run <= 1'b0;
        end else if (wr && wb_adr_i == ADDR_CTRL0 && wb_sel_i[0]) begin
            run <= wb_dat_i[RUN_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_run_up;
        wr && wb_adr_i == ADDR_CTRL0 && wb_dat_i[RUN_BIT] && !run && ctrl[7:6] == MODE_CMP;
    endsequence
    sequence s_cmp_pf(logic [1:0] f);
        settled && ctrl[7:6] == MODE_CMP && ctrl[5:4] == f;
    endsequence
    property p_run_load;
        s_run_up |-> ##[1:3] timer_out == init_lvl;
    endproperty
    a_run_load: assert property (p_run_load) else $error("pin not loaded on run");
    property p_cmp_en;
        settled && ctrl[7:6] == MODE_CMP |-> timer_out_en;
    endproperty
    a_cmp_en: assert property (p_cmp_en) else $error("compare mode pin undriven");
    property p_timer_en;
        settled && ctrl[7:6] == MODE_TIMER |-> !timer_out_en;
    endproperty
    a_timer_en: assert property (p_timer_en) else $error("timer mode drives pin");
    property p_keep;
        s_cmp_pf(PF_KEEP) |-> $stable(timer_out);
    endproperty
    a_keep: assert property (p_keep) else $error("pin moved with keep");
    property p_low;
        s_cmp_pf(PF_LOW) |-> !$rose(timer_out);
    endproperty
    a_low: assert property (p_low) else $error("pin rose with low select");
    property p_high;
        s_cmp_pf(PF_HIGH) |-> !$fell(timer_out);
    endproperty
    a_high: assert property (p_high) else $error("pin fell with high select");
    property p_pwm_off;
        settled && run && ctrl[7:4] == {MODE_PWM, PF_PWM_OFF} |-> timer_out == !init_lvl;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("forced inactive wrong");
    property p_pwm_on;
        settled && run && ctrl[7:4] == {MODE_PWM, PF_PWM_ON} |-> timer_out == init_lvl;
    endproperty
    a_pwm_on: assert property (p_pwm_on) else $error("forced active wrong");
endmodule
bind standard_timer standard_timer_chk chk_u (
    .clk(clk),
    .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o),
    .timer_out(timer_out),
    .timer_out_en(timer_out_en)
);
`default_nettype wire

// file: tb/pin_load_model.sv
// load on the timer pin: tallies high clocks and rises; drives the trigger pin
// assumes the bench resolves the pin level (pull-down when undriven)
`timescale 1ns/100ps
`default_nettype none
module pin_load_model (
    input wire logic clk, // system clock
    input wire logic pin, // resolved pin level
    input wire logic clear, // restart the tallies
    input wire logic fire, // hold high to raise the trigger pin
    output logic ext_pin, // trigger pin
    output int high_cnt, // clocks seen high
    output int rises // rising edges seen
);
    logic last = 1'b0;
    initial ext_pin = 1'b0;
    always @(posedge clk) begin
        ext_pin <= fire;
        last <= pin;
        if (clear) begin
            high_cnt <= 0;
            rises <= 0;
        end else begin
            high_cnt <= high_cnt + int'(pin);
            rises <= rises + int'(pin && !last);
        end
    end
endmodule
`default_nettype wire

// file: tb/standard_timer_tb.sv
// self-checking bench for the standard timer: bus tasks, read scoreboard, pin load
// assumes divider 0, so one timer tick per clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module standard_timer_tb;
    import timer_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, timer_out, timer_out_en, ext_pin, pin;
    logic clear = 1'b0;
    logic fire = 1'b0;
    int high_cnt, rises;
    int checks = 0;
    int mismatches = 0;
    logic [31:0] seed = 32'd20;
    logic [31:0] expq [$];
    logic [7:0] pcfg [7] = '{8'ha8, 8'hac, 8'haa, 8'haa, 8'h88, 8'h98, 8'ha9};
    logic [9:0] pa [7] = '{10'd32, 10'd32, 10'd512, 10'd64, 10'd32, 10'd32, 10'd32};
    int phigh [7] = '{256, 768, 256, 1024, 0, 1024, 256};
    logic [31:0] pst [7] = '{32'h3, 32'h3, 32'h3, 32'h1, 32'h3, 32'h3, 32'h3};
    assign pin = timer_out_en ? timer_out : 1'b0; // pull-down when undriven
    standard_timer #(.DIV_W(8)) dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .external_clock_pin(ext_pin), .timer_out(timer_out), .timer_out_en(timer_out_en));
    pin_load_model load_u (.clk(clk), .pin(pin), .clear(clear), .fire(fire),
        .ext_pin(ext_pin), .high_cnt(high_cnt), .rises(rises));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            end_of_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic tally_clear();
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
    endtask
    // read data is judged where it appears, against the oldest expectation
    always @(posedge clk) begin
        logic [31:0] e;
        if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
            e = expq.pop_front();
            `CHK("read data", e, wb_dat_o)
        end
    end
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        logic [9:0] a;
        logic [1:0] pf;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_CTRL1, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        seed = xs(seed);
        wr(8'h40, seed);
        rd(8'h40, 32'h0);
        wr(ADDR_DIVIDER, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pf = 2'(i);
            seed = xs(seed);
            a = 10'(seed[4:0]) + 10'd8; // never zero in compare mode
            wr(ADDR_CMPA, {22'h0, a});
            wr(ADDR_CTRL1, {24'h0, MODE_CMP, pf, 3'b100, pf[0]});
            wr(ADDR_CTRL0, 32'h9);
            repeat (3) @(posedge clk);
            `CHK("initial level", 1'b1, timer_out)
            tally_clear();
            repeat (300) @(posedge clk);
            if (pf == PF_TOGGLE) begin
                `CHK("toggled", 1'b1, rises > 0)
            end else begin
                `CHK("pin level", (pf != PF_LOW), timer_out)
                `CHK("pin rises", 0, rises)
            end
            rd(ADDR_STATUS, pf[0] ? 32'h1 : 32'h3);
            wr(ADDR_CTRL0, 32'h0);
            wr(ADDR_STATUS, 32'h3);
        end
        wr(ADDR_CTRL1, {24'h0, MODE_TIMER, 6'b000001});
        wr(ADDR_CTRL0, 32'h8);
        repeat (100) @(posedge clk);
        `CHK("pin driven", 1'b0, timer_out_en)
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_CTRL0, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_CTRL1, {24'h0, pcfg[i]});
            wr(ADDR_CMPA, {22'h0, pa[i]});
            wr(ADDR_CTRL0, 32'h9);
            repeat (300) @(posedge clk);
            tally_clear();
            repeat (1025) @(posedge clk);
            `CHK("high clocks", phigh[i], high_cnt)
            rd(ADDR_STATUS, pst[i]);
            wr(ADDR_CTRL0, 32'h0);
            wr(ADDR_STATUS, 32'h3);
        end
        wr(ADDR_CTRL1, {24'h0, MODE_PWM, PF_PULSE, 4'b1000});
        wr(ADDR_CMPA, 32'd50);
        tally_clear();
        fire <= 1'b1;
        repeat (4) @(posedge clk);
        fire <= 1'b0;
        repeat (150) @(posedge clk);
        // the run rise only zeroes the counter, so fifty steps span one extra clock
        `CHK("pulse width", 51, high_cnt)
        rd(ADDR_CTRL0, 32'h0);
        rd(ADDR_STATUS, 32'h1);
        tally_clear();
        wr(ADDR_CTRL0, 32'h8); // held high while the pulse should last
        repeat (10) @(posedge clk);
        wr(ADDR_CTRL0, 32'h0);
        repeat (5) @(posedge clk);
        `CHK("pin after stop", 1'b0, timer_out)
        `CHK("pulse count", 1, rises)
        end_of_test();
    end
endmodule
`default_nettype wire
